//--- design/opag_pkg.sv
package opag_pkg;
  // Data and register file shape
  localparam int WORD_W = 16;
  localparam int BYTE_W = 8;
  localparam int REG_COUNT = 8;
  localparam logic [2:0] SP_INDEX = 3'h6;
  localparam logic [2:0] PC_INDEX = 3'h7;
  localparam logic [15:0] REG_RESET = 16'h0000;
  // Instruction word fields
  localparam int SPEC_W = 6;
  localparam int DST_LSB = 0;
  localparam int SRC_LSB = 6;
  localparam int BYTE_BIT = 15;
  localparam int REG_LSB = 0;
  localparam int MODE_LSB = 3;
  // Mode field codes: upper two bits pick the kind, low bit adds indirection
  localparam logic [1:0] KIND_REG = 2'h0;
  localparam logic [1:0] KIND_AUTOINC = 2'h1;
  localparam logic [1:0] KIND_AUTODEC = 2'h2;
  localparam logic [1:0] KIND_INDEX = 2'h3;
  // Pointer step sizes
  localparam logic [15:0] STEP_WORD = 16'h0002;
  localparam logic [15:0] STEP_BYTE = 16'h0001;
  // Processor cycle timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int PROC_CYCLE_NS = 260;
  localparam int TIMING_TOLERANCE_PCT = 10;
  localparam int PROC_TICK_CYCLES = (PROC_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICK_W = 5;
  localparam int CYC_W = 8;
  localparam logic [4:0] TICK_LAST = 5'(PROC_TICK_CYCLES - 1);
  // Sequencer states
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_RESOLVE = 4'h1,
    ST_INDEX = 4'h2,
    ST_DEFER = 4'h3,
    ST_OPERAND = 4'h4,
    ST_NEXT = 4'h5,
    ST_EXEC = 4'h6,
    ST_WRITE = 4'h7,
    ST_PUSH = 4'h8,
    ST_POP = 4'h9,
    ST_DONE = 4'hA
  } opag_state_e;
endpackage : opag_pkg

//--- design/opag_spec_if.sv
`timescale 1ns/1ns
interface opag_spec_if;
  logic [5:0] spec;
  logic byte_op;
  logic [2:0] reg_sel;
  logic direct_reg;
  logic autoinc;
  logic autodec;
  logic indexed;
  logic deferred;
  logic [15:0] step;
  modport decoder (input spec, input byte_op, output reg_sel, output direct_reg,
                   output autoinc, output autodec, output indexed, output deferred,
                   output step);
  modport user (output spec, output byte_op, input reg_sel, input direct_reg,
                input autoinc, input autodec, input indexed, input deferred,
                input step);
endinterface : opag_spec_if

//--- design/opag_mode_decoder.sv
`timescale 1ns/1ns
module opag_mode_decoder
  import opag_pkg::*;
(
  opag_spec_if.decoder dec  // Specifier in, mode controls out
);
  logic [1:0] kind;

  // Step size: byte only for a direct byte pointer that is not SP or PC
  function automatic logic [15:0] step_size(input logic byte_op, input logic defer,
                                            input logic [2:0] rsel);
    logic [15:0] s;
    s = STEP_WORD;
    if (byte_op && !defer && (rsel != SP_INDEX) && (rsel != PC_INDEX))
    begin
      s = STEP_BYTE;
    end
    return s;
  endfunction : step_size

  // Split the specifier into register and mode kind
  assign kind = dec.spec[MODE_LSB+2 -: 2];
  assign dec.reg_sel = dec.spec[REG_LSB +: 3];
  assign dec.deferred = dec.spec[MODE_LSB];
  assign dec.direct_reg = (kind == KIND_REG);
  assign dec.autoinc = (kind == KIND_AUTOINC);
  assign dec.autodec = (kind == KIND_AUTODEC);
  assign dec.indexed = (kind == KIND_INDEX);
  // Deferred stepping is always by a word since it walks address words
  assign dec.step = step_size(dec.byte_op, dec.spec[MODE_LSB], dec.spec[REG_LSB +: 3]);
endmodule : opag_mode_decoder

//--- design/opag_operand_address_generator.sv
`timescale 1ns/1ns
// Overview of operation
// - Operands are words or bytes per instruction
// - Specifier holds register select and mode
// - Register mode uses register, no memory
// - Deferred mode uses register as address
// - Autoincrement steps after, autodecrement before
// - Index adds following word to register
// - Linkage push and pop use register six
// - Any register may step as stack
// - Register seven is program counter
// - Single and double operand forms supported
// - Time is basic plus operand cycles
// - Processor cycle 260 ns, ten percent slack
// - Deferred step modes always step by two
// - Index leaves offset and base register unchanged unless the base is PC
module opag_operand_address_generator
(
  input wire logic ref_clk_in,  // 100 MHz clock
  input wire logic rst_in,  // Async reset, active high
  input wire logic start_in,  // Start operand resolution
  input wire logic [15:0] instr_in,  // Instruction word
  input wire logic double_op_in,  // High for two specifiers
  input wire logic [7:0] basic_cycles_in,  // Basic time in processor cycles
  input wire logic push_in,  // Implicit push onto hardware stack
  input wire logic pop_in,  // Implicit pop from hardware stack
  input wire logic [15:0] push_data_in,  // Word to push
  input wire logic result_valid_in,  // Result ready for write back
  input wire logic [15:0] result_in,  // Result value
  input wire logic [2:0] reg_sel_in,  // Register view select
  output logic [15:0] reg_value_out,  // Selected register value
  output logic mem_req_out,  // Memory request, held until ack
  output logic mem_write_out,  // Memory write when high
  output logic mem_byte_out,  // Byte access when high
  output logic [15:0] mem_addr_out,  // Memory address
  output logic [15:0] mem_wdata_out,  // Memory write data
  input wire logic [15:0] mem_rdata_in,  // Memory read data
  input wire logic mem_ack_in,  // Memory transfer done
  output logic operands_valid_out,  // Operands stand ready
  output logic [15:0] src_data_out,  // Source operand
  output logic [15:0] src_addr_out,  // Source address
  output logic [15:0] dst_data_out,  // Destination operand or popped word
  output logic [15:0] dst_addr_out,  // Destination address
  output logic dst_is_reg_out,  // Destination is a register
  output logic busy_out,  // Sequencer active
  output logic done_out,  // One-cycle completion pulse
  output logic [7:0] exec_cycles_out  // Total time in processor cycles
);
  import opag_pkg::*;
  opag_state_e state;
  logic [15:0] regs [REG_COUNT];
  logic [15:0] ir;
  logic byte_op;
  logic phase;
  logic [15:0] op_addr;
  logic [15:0] op_data;
  logic op_is_reg;
  logic [15:0] wdata_hold;
  logic [TICK_W-1:0] tick_cnt;
  logic proc_tick;
  logic [CYC_W-1:0] op_cycles;
  logic [CYC_W-1:0] basic_hold;
  logic [15:0] sel_val;
  logic [15:0] dec_val;
  logic [15:0] index_base;
  logic [2:0] rs;
  opag_spec_if spec_bus ();
  // Pick the source or destination specifier by phase
  assign spec_bus.spec = phase ? ir[DST_LSB +: SPEC_W] : ir[SRC_LSB +: SPEC_W];
  assign spec_bus.byte_op = byte_op;
  opag_mode_decoder u_decoder (
    .dec (spec_bus.decoder)
  );
  // Register-derived values used by the sequencer
  assign rs = spec_bus.reg_sel;
  assign sel_val = regs[rs];
  assign dec_val = sel_val - spec_bus.step;
  // Relative addressing uses the program counter already past the offset word
  assign index_base = (rs == PC_INDEX) ? (regs[PC_INDEX] + STEP_WORD) : sel_val;
  // Processor cycle enable from the fast clock
  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      tick_cnt <= '0;
    end
    else
    begin
      tick_cnt <= proc_tick ? '0 : tick_cnt + 5'h01;
    end
  end
  assign proc_tick = (tick_cnt == TICK_LAST);
  // Count processor cycles spent in every sequencer state except idle
  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      op_cycles <= '0;
    end
    else if (state == ST_IDLE)
    begin
      op_cycles <= '0;
    end
    else if (proc_tick && (op_cycles != 8'hFF))
    begin
      op_cycles <= op_cycles + 8'h01;
    end
  end

  // Sequencer with register file and operand latches
  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state <= ST_IDLE;
      for (int i = 0; i < REG_COUNT; i++)
      begin
        regs[i] <= REG_RESET;
      end
      ir <= '0;
      byte_op <= 1'b0;
      phase <= 1'b0;
      op_addr <= '0;
      op_data <= '0;
      op_is_reg <= 1'b0;
      wdata_hold <= '0;
      src_data_out <= '0;
      src_addr_out <= '0;
      basic_hold <= '0;
      exec_cycles_out <= '0;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          if (start_in)
          begin
            ir <= instr_in;
            byte_op <= instr_in[BYTE_BIT];
            phase <= ~double_op_in;
            basic_hold <= basic_cycles_in;
            state <= ST_RESOLVE;
          end
          else if (push_in)
          begin
            byte_op <= 1'b0;
            wdata_hold <= push_data_in;
            basic_hold <= basic_cycles_in;
            state <= ST_PUSH;
          end
          else if (pop_in)
          begin
            byte_op <= 1'b0;
            op_addr <= regs[SP_INDEX];
            basic_hold <= basic_cycles_in;
            state <= ST_POP;
          end
        end
        ST_RESOLVE:
        begin
          if (proc_tick)
          begin
            op_is_reg <= spec_bus.direct_reg && !spec_bus.deferred;
            if (spec_bus.direct_reg && !spec_bus.deferred)
            begin
              op_addr <= '0;
              op_data <= byte_op ? {8'h00, sel_val[7:0]} : sel_val;
              state <= ST_NEXT;
            end
            else if (spec_bus.direct_reg)
            begin
              op_addr <= sel_val;
              state <= ST_OPERAND;
            end
            else if (spec_bus.autoinc)
            begin
              op_addr <= sel_val;
              regs[rs] <= sel_val + spec_bus.step;
              state <= spec_bus.deferred ? ST_DEFER : ST_OPERAND;
            end
            else if (spec_bus.autodec)
            begin
              op_addr <= dec_val;
              regs[rs] <= dec_val;
              state <= spec_bus.deferred ? ST_DEFER : ST_OPERAND;
            end
            else
            begin
              op_addr <= regs[PC_INDEX];
              state <= ST_INDEX;
            end
          end
        end
        ST_INDEX:
        begin
          if (mem_ack_in)
          begin
            // Sum goes to a latch; offset stays untouched, base register too unless it is PC
            op_addr <= mem_rdata_in + index_base;
            regs[PC_INDEX] <= regs[PC_INDEX] + STEP_WORD;
            state <= spec_bus.deferred ? ST_DEFER : ST_OPERAND;
          end
        end
        ST_DEFER:
        begin
          if (mem_ack_in)
          begin
            op_addr <= mem_rdata_in;
            state <= ST_OPERAND;
          end
        end
        ST_OPERAND:
        begin
          if (mem_ack_in)
          begin
            op_data <= !byte_op ? mem_rdata_in :
                       {8'h00, op_addr[0] ? mem_rdata_in[15:8] : mem_rdata_in[7:0]};
            state <= ST_NEXT;
          end
        end
        ST_NEXT:
        begin
          if (!phase)
          begin
            src_data_out <= op_data;
            src_addr_out <= op_addr;
          end
          phase <= 1'b1;
          state <= phase ? ST_EXEC : ST_RESOLVE;
        end
        ST_EXEC:
        begin
          if (result_valid_in)
          begin
            // Byte results go out on both lanes so an odd address lands too
            wdata_hold <= byte_op ? {2{result_in[7:0]}} : result_in;
            if (op_is_reg)
            begin
              regs[rs] <= byte_op ? {sel_val[15:8], result_in[7:0]} : result_in;
            end
            state <= op_is_reg ? ST_DONE : ST_WRITE;
          end
        end
        ST_WRITE:
        begin
          if (mem_ack_in)
          begin
            state <= ST_DONE;
          end
        end
        ST_PUSH:
        begin
          if (proc_tick)
          begin
            regs[SP_INDEX] <= regs[SP_INDEX] - STEP_WORD;
            op_addr <= regs[SP_INDEX] - STEP_WORD;
            state <= ST_WRITE;
          end
        end
        ST_POP:
        begin
          if (mem_ack_in)
          begin
            op_data <= mem_rdata_in;
            regs[SP_INDEX] <= regs[SP_INDEX] + STEP_WORD;
            state <= ST_DONE;
          end
        end
        ST_DONE:
        begin
          exec_cycles_out <= basic_hold + op_cycles;
          state <= ST_IDLE;
        end
        default:
        begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Memory handshake and operand outputs
  assign mem_req_out = (state == ST_INDEX) || (state == ST_DEFER) || (state == ST_OPERAND) ||
                       (state == ST_WRITE) || (state == ST_POP);
  assign mem_write_out = (state == ST_WRITE);
  assign mem_byte_out = byte_op && ((state == ST_OPERAND) || (state == ST_WRITE));
  assign mem_addr_out = op_addr;
  assign mem_wdata_out = wdata_hold;
  assign operands_valid_out = (state == ST_EXEC);
  assign dst_data_out = op_data;
  assign dst_addr_out = op_addr;
  assign dst_is_reg_out = op_is_reg;
  assign busy_out = (state != ST_IDLE);
  assign done_out = (state == ST_DONE);
  assign reg_value_out = regs[reg_sel_in];
endmodule : opag_operand_address_generator

//--- testbench/opag_memory_model.sv
`timescale 1ns/1ns
module opag_memory_model (
  input wire logic clk_in,  // Clock
  input wire logic req_in,  // Request
  input wire logic wr_in,  // Write when high
  input wire logic byte_in,  // Byte lane access
  input wire logic [15:0] addr_in,  // Address
  input wire logic [15:0] wdata_in,  // Write data
  input wire logic slow_in,  // Stretch each answer
  output logic ack_out,  // One-cycle answer
  output logic [15:0] rdata_out  // Read data
);
  logic [15:0] mem [0:255];
  int wait_n;
  // Clear storage
  initial
  begin
    foreach (mem[i]) mem[i] = 16'h0000;
    wait_n = 0;
    ack_out = 1'b0;
    rdata_out = 16'h0000;
  end
  // Answer each request once; data lines toggle while not answering
  always @(posedge clk_in)
  begin
    ack_out <= 1'b0;
    rdata_out <= ~rdata_out;
    if (req_in && !ack_out && wait_n < (slow_in ? 3 : 0))
      wait_n <= wait_n + 1;
    else if (req_in && !ack_out)
    begin
      wait_n <= 0;
      ack_out <= 1'b1;
      if (!wr_in)
        rdata_out <= mem[addr_in[8:1]];
      else if (!byte_in)
        mem[addr_in[8:1]] <= wdata_in;
      else if (addr_in[0])
        mem[addr_in[8:1]][15:8] <= wdata_in[15:8];
      else
        mem[addr_in[8:1]][7:0] <= wdata_in[7:0];
    end
  end
endmodule : opag_memory_model

//--- testbench/opag_operand_address_generator_monitor.sv
`timescale 1ns/1ns
module opag_operand_address_generator_monitor (
  input wire logic ref_clk_in,  // Clock
  input wire logic rst_in,  // Reset
  input wire logic start_in,  // Start
  input wire logic result_valid_in,  // Result given
  input wire logic mem_ack_in,  // Memory answer
  input wire logic mem_req_out,  // Memory request
  input wire logic mem_write_out,  // Memory write
  input wire logic [15:0] mem_addr_out,  // Memory address
  input wire logic operands_valid_out,  // Operands ready
  input wire logic dst_is_reg_out,  // Register destination
  input wire logic busy_out,  // Busy
  input wire logic done_out  // Done pulse
);
  default clocking mon_cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  // Handshake and sequencing checks
  req_hold_a: assert property (mem_req_out && !mem_ack_in |=> mem_req_out
    && $stable(mem_addr_out) && $stable(mem_write_out)) else $error("request not held");
  done_once_a: assert property (done_out |=> !done_out && !busy_out)
    else $error("done not a single pulse");
  start_busy_a: assert property (start_in && !busy_out |=> busy_out)
    else $error("start not taken");
  valid_hold_a: assert property (operands_valid_out && !result_valid_in |=>
    operands_valid_out) else $error("operands valid dropped");
  valid_quiet_a: assert property (operands_valid_out |-> !mem_req_out)
    else $error("memory request while operands valid");
  write_req_a: assert property (mem_write_out |-> mem_req_out)
    else $error("write without request");
  idle_quiet_a: assert property (!busy_out |-> !mem_req_out && !operands_valid_out)
    else $error("activity while idle");
  reg_done_a: assert property (operands_valid_out && result_valid_in && dst_is_reg_out
    |=> done_out) else $error("register result not done next cycle");
endmodule : opag_operand_address_generator_monitor
bind opag_operand_address_generator opag_operand_address_generator_monitor i_mon (.ref_clk_in,
  .rst_in, .start_in, .result_valid_in, .mem_ack_in, .mem_req_out, .mem_write_out, .mem_addr_out,
  .operands_valid_out, .dst_is_reg_out, .busy_out, .done_out);

//--- testbench/opag_operand_address_generator_bench.sv
`timescale 1ns/1ns
module opag_operand_address_generator_bench;
  import opag_pkg::*;
  logic ref_clk_in, rst_in, start_in, double_op_in, push_in, pop_in, result_valid_in, mem_ack_in;
  logic mem_req_out, mem_write_out, mem_byte_out, operands_valid_out, dst_is_reg_out;
  logic busy_out, done_out, slow;
  logic [15:0] instr_in, push_data_in, result_in, mem_rdata_in, reg_value_out, mem_addr_out;
  logic [15:0] mem_wdata_out, src_data_out, src_addr_out, dst_data_out, dst_addr_out, ca, cd, cs;
  logic [7:0] basic_cycles_in, exec_cycles_out;
  logic [2:0] reg_sel_in;
  int bad_count, checks, cyc;
  opag_operand_address_generator i_dut (.ref_clk_in, .rst_in, .start_in, .instr_in, .double_op_in,
    .basic_cycles_in, .push_in, .pop_in, .push_data_in, .result_valid_in, .result_in, .reg_sel_in,
    .reg_value_out, .mem_req_out, .mem_write_out, .mem_byte_out, .mem_addr_out, .mem_wdata_out,
    .mem_rdata_in, .mem_ack_in, .operands_valid_out, .src_data_out, .src_addr_out, .dst_data_out,
    .dst_addr_out, .dst_is_reg_out, .busy_out, .done_out, .exec_cycles_out);
  opag_memory_model i_mem (.clk_in(ref_clk_in), .req_in(mem_req_out), .wr_in(mem_write_out),
    .byte_in(mem_byte_out), .addr_in(mem_addr_out), .wdata_in(mem_wdata_out), .slow_in(slow),
    .ack_out(mem_ack_in), .rdata_out(mem_rdata_in));
  // Clock
  initial
  begin
    ref_clk_in = 1'b0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end
  // Hang guard
  always @(posedge ref_clk_in)
  begin
    cyc++;
    if (cyc == 50000)
    begin
      bad_count++;
      end_sim();
    end
  end
  task automatic end_sim;
    if (bad_count == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_sim
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    checks++;
    if (s !== e)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic reg_is(input logic [2:0] r, input logic [15:0] e);
    reg_sel_in = r;
    #1 chk("register", e, reg_value_out);
  endtask : reg_is
  task automatic wait_done;
    int n;
    n = 0;
    while (done_out !== 1'b1 && n++ < 3000) @(negedge ref_clk_in);
    chk("done", 16'h0001, 16'(done_out));
    @(negedge ref_clk_in);
  endtask : wait_done
  // One instruction: start, capture operands, hand back a result
  task automatic op(input logic [15:0] ins, input logic [15:0] r);
    int n;
    instr_in = ins;
    double_op_in = |ins[11:6];
    start_in = 1'b1;
    @(negedge ref_clk_in);
    start_in = 1'b0;
    n = 0;
    while (operands_valid_out !== 1'b1 && n++ < 3000) @(negedge ref_clk_in);
    chk("operands valid", 16'h0001, 16'(operands_valid_out));
    ca = dst_addr_out;
    cd = dst_data_out;
    cs = src_data_out;
    result_in = r;
    result_valid_in = 1'b1;
    @(negedge ref_clk_in);
    result_valid_in = 1'b0;
    wait_done();
  endtask : op
  task automatic setr(input logic [2:0] r, input logic [15:0] v);
    op(16'(r), v);
  endtask : setr
  task automatic t_reg;
    setr(3'h3, 16'hA5C3);
    reg_is(3'h3, 16'hA5C3);
    chk("dst is reg", 16'h0001, 16'(dst_is_reg_out));
    chk("exec time", 16'h0001, 16'(exec_cycles_out > basic_cycles_in));
    chk("exec cycles", 16'h0011, 16'(exec_cycles_out));
  endtask : t_reg
  task automatic t_ptr;
    slow = 1'b1;
    setr(3'h1, 16'h0040);
    i_mem.mem[8'h20] = 16'h1234;
    op(16'o000011, 16'h5555);
    chk("dst addr", 16'h0040, ca);
    chk("dst data", 16'h1234, cd);
    chk("memory", 16'h5555, i_mem.mem[8'h20]);
    reg_is(3'h1, 16'h0040);
    chk("dst is reg", 16'h0000, 16'(dst_is_reg_out));
    slow = 1'b0;
  endtask : t_ptr
  task automatic t_step;
    op(16'o000021, 16'h0000);
    chk("dst addr", 16'h0040, ca);
    reg_is(3'h1, 16'h0042);
    setr(3'h2, 16'h0050);
    op(16'o000042, 16'h0000);
    chk("dst addr", 16'h004E, ca);
    reg_is(3'h2, 16'h004E);
    op(16'o100021, 16'h0000);
    reg_is(3'h1, 16'h0043);
    op(16'o100031, 16'h0000);
    reg_is(3'h1, 16'h0045);
    i_mem.mem[8'h22] = 16'h12AB;
    op(16'o100011, 16'h00CD);
    chk("byte data", 16'h0012, cd);
    chk("memory", 16'hCDAB, i_mem.mem[8'h22]);
  endtask : t_step
  task automatic t_index;
    setr(3'h1, 16'h0040);
    setr(3'h7, 16'h0020);
    i_mem.mem[8'h10] = 16'h0010;
    op(16'o000061, 16'h0000);
    chk("dst addr", 16'h0050, ca);
    reg_is(3'h1, 16'h0040);
    chk("offset", 16'h0010, i_mem.mem[8'h10]);
    reg_is(3'h7, 16'h0022);
    op(16'o000027, 16'h0000);
    chk("dst addr", 16'h0022, ca);
    reg_is(3'h7, 16'h0024);
    i_mem.mem[8'h12] = 16'h0004;
    op(16'o000067, 16'h0000);
    chk("dst addr", 16'h002A, ca);
    reg_is(3'h7, 16'h0026);
  endtask : t_index
  task automatic t_double;
    setr(3'h4, 16'h0060);
    i_mem.mem[8'h30] = 16'h0BAD;
    op(16'o002405, 16'h7777);
    chk("src data", 16'h0BAD, cs);
    chk("src addr", 16'h0060, src_addr_out);
    reg_is(3'h4, 16'h0062);
    reg_is(3'h5, 16'h7777);
  endtask : t_double
  task automatic t_stack;
    setr(3'h6, 16'h0080);
    push_data_in = 16'hBEEF;
    push_in = 1'b1;
    @(negedge ref_clk_in);
    push_in = 1'b0;
    wait_done();
    reg_is(3'h6, 16'h007E);
    chk("pushed", 16'hBEEF, i_mem.mem[8'h3F]);
    pop_in = 1'b1;
    @(negedge ref_clk_in);
    pop_in = 1'b0;
    wait_done();
    chk("popped", 16'hBEEF, dst_data_out);
    reg_is(3'h6, 16'h0080);
  endtask : t_stack
  // Main sequence
  initial
  begin
    rst_in = 1'b1;
    {start_in, double_op_in, push_in, pop_in, result_valid_in, slow} = 6'h00;
    {instr_in, push_data_in, result_in} = 48'h0;
    basic_cycles_in = 8'h10;
    reg_sel_in = 3'h0;
    repeat (16) @(posedge ref_clk_in);
    @(negedge ref_clk_in);
    rst_in = 1'b0;
    t_reg();
    t_ptr();
    t_step();
    t_index();
    t_double();
    t_stack();
    end_sim();
  end
endmodule : opag_operand_address_generator_bench
